// ==== hdl/rtc_pkg.sv ====
`default_nettype none

package rtc_pkg;

  // Register indices; byte address is four times the index
  localparam logic [11:0] IDX_YEAR = 12'hF36;
  localparam logic [11:0] IDX_ALARM_SECOND_FIELD = 12'hF37;
  localparam logic [11:0] IDX_ALARM_MINUTE_FIELD = 12'hF38;
  localparam logic [11:0] IDX_CFG  = 12'hF40;
  localparam logic [11:0] IDX_STAT = 12'hF41;
  localparam logic [11:0] IDX_MASK = 12'hF42;

  // Index field position inside the byte address
  localparam int IDX_LSB = 2;
  localparam int IDX_MSB = 13;

  // Active-field masks per format
  localparam logic [7:0] MASK_FULL     = 8'hFF;
  localparam logic [7:0] MASK_YEAR_BIN = 8'h7F;
  localparam logic [7:0] MASK_ALM_BCD  = 8'h7F;
  localparam logic [7:0] MASK_ALM_BIN  = 8'h3F;

  // Digit field positions
  localparam int TENS_MSB = 7;
  localparam int TENS_LSB = 4;
  localparam int ONES_MSB = 3;
  localparam int ONES_LSB = 0;

  // Configuration bits
  localparam int CFG_BCD_BIT  = 0;
  localparam int CFG_MODE_BIT = 1;
  localparam int CFG_LOCK_BIT = 2;
  localparam int CFG_W        = 3;
  localparam logic [2:0] CFG_RST = 3'h0;

  // Event bits, shared by status and mask
  localparam int EV_ALARM  = 0;
  localparam int EV_LOCKED = 1;
  localparam int EV_RSVD   = 2;
  localparam int EV_W      = 3;
  localparam logic [2:0] STAT_RST = 3'h0;
  localparam logic [2:0] MASK_RST = 3'h0;

  typedef struct packed {
    logic lock;
    logic counter_mode;
    logic bcd_en;
  } cfg_t;

  typedef struct packed {
    logic [7:0] b3;
    logic [7:0] b2;
    logic [7:0] b1;
    logic [7:0] b0;
  } alarm_word_t;

  typedef struct packed {
    logic [7:0] seconds;
    logic [7:0] minutes;
  } clock_time_t;

endpackage

`default_nettype wire

// ==== hdl/rtc_keep_byte.sv ====
`timescale 1ns/100ps
`default_nettype none

module rtc_keep_byte #(
  parameter int WIDTH = 8
) (
  input  wire logic             pclk,
  input  wire logic             load,
  input  wire logic [WIDTH-1:0] load_value,
  output logic      [WIDTH-1:0] value
);

  logic [WIDTH-1:0] next_value;

  always_comb begin
    next_value = load ? load_value : value;
  end

  // No reset: contents survive power-on reset
  always_ff @(posedge pclk) begin // see R1
    value <= next_value;
  end

endmodule

`default_nettype wire

// ==== hdl/rtc_year_alarm_regs.sv ====
`timescale 1ns/100ps
`default_nettype none

// Contract
// R1 - Year, alarm seconds and alarm minutes keep contents through power-on reset.
// R2 - Decimal select chooses packed decimal (set) or plain binary (clear) meaning.
// R3 - Year accepts writes only while unlocked; locked writes are dropped.
// R4 - Decimal year: tens digit in bits 7:4, ones digit in bits 3:0.
// R5 - Binary year: count 0x00..0x63 in bits 6:0, bit 7 reserved.
// R6 - Decimal alarm seconds: tens in 6:4, ones in 3:0, bit 7 reserved.
// R7 - Binary alarm seconds: value 0x00..0x3B in bits 5:0, top two reserved.
// R8 - Counter mode: alarm seconds byte is alarm word byte 3, all bits.
// R9 - Decimal alarm minutes: tens in 6:4, ones in 3:0, bit 7 reserved.
// R10 - Binary alarm minutes: value 0x00..0x3B in bits 5:0, top two reserved.
// R11 - Counter mode: alarm minutes byte is alarm word byte 2, all bits.
// R12 - Software writes zero to every bit reserved under the active format.
// R13 - Counter mode: alarm hours gives byte 1, alarm day gives byte 0.
// R14 - Alarm bytes writable regardless of lock; they feed the alarm compare.
module rtc_year_alarm_regs #(
  parameter int ADDR_W = 16
) (
  input  wire logic              pclk,
  input  wire logic              presetn,
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [ADDR_W-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic      [31:0]       prdata,
  output logic                   pready,
  output logic                   pslverr,
  input  wire logic [7:0]        alarm_hours_byte,
  input  wire logic [7:0]        alarm_dom_byte,
  input  wire logic [7:0]        count_seconds,
  input  wire logic [7:0]        count_minutes,
  input  wire logic [31:0]       count_word,
  output logic [31:0]            alarm_word,
  output logic [7:0]             year_value,
  output logic                   alarm_match,
  output logic                   irq
);

  rtc_pkg::cfg_t                    cfg;
  rtc_pkg::cfg_t                    next_cfg;
  logic [rtc_pkg::EV_W-1:0]         status;
  logic [rtc_pkg::EV_W-1:0]         next_status;
  logic [rtc_pkg::EV_W-1:0]         int_mask;
  logic [rtc_pkg::EV_W-1:0]         next_int_mask;
  logic [rtc_pkg::EV_W-1:0]         events;
  logic [31:0]                      next_prdata;
  logic                             next_pslverr;
  logic                             next_irq;
  logic                             next_alarm_match;
  logic                             match_now;
  logic [7:0]                       year_raw;
  logic [7:0]                       alarm_second_field_raw;
  logic [7:0]                       alarm_minute_field_raw;
  logic [7:0]                       year_mask;
  logic [7:0]                       alm_mask;
  logic [7:0]                       wbyte;
  logic [11:0]                      idx;
  logic                             idx_ok;
  logic                             setup;
  logic                             access;
  logic                             wr;
  logic                             rd;
  logic                             hit_year;
  logic                             hit_alarm_second_field;
  logic                             hit_alarm_minute_field;
  logic                             hit_cfg;
  logic                             hit_stat;
  logic                             hit_mask;
  logic                             mapped;
  logic                             year_load;
  logic                             year_dropped;
  logic                             rsvd_written;
  logic                             stat_clear;
  rtc_pkg::alarm_word_t             aw;
  rtc_pkg::clock_time_t             alm_time;
  rtc_pkg::clock_time_t             cnt_time;

  // Bus decode
  assign setup  = psel && !penable;
  assign access = psel && penable;
  assign wr     = access && pwrite;
  assign rd     = access && !pwrite;
  assign pready = 1'b1;
  assign wbyte  = pwdata[7:0];
  // Status read and clear share the setup edge, so no event is lost
  assign stat_clear = setup && !pwrite && hit_stat;

  always_comb begin
    idx    = paddr[rtc_pkg::IDX_MSB:rtc_pkg::IDX_LSB];
    idx_ok = (paddr[1:0] == 2'h0);
    if (ADDR_W > rtc_pkg::IDX_MSB + 1) begin
      idx_ok = idx_ok && (paddr >> (rtc_pkg::IDX_MSB + 1)) == '0;
    end
  end

  assign hit_year = idx_ok && (idx == rtc_pkg::IDX_YEAR);
  assign hit_alarm_second_field = idx_ok && (idx == rtc_pkg::IDX_ALARM_SECOND_FIELD);
  assign hit_alarm_minute_field = idx_ok && (idx == rtc_pkg::IDX_ALARM_MINUTE_FIELD);
  assign hit_cfg  = idx_ok && (idx == rtc_pkg::IDX_CFG);
  assign hit_stat = idx_ok && (idx == rtc_pkg::IDX_STAT);
  assign hit_mask = idx_ok && (idx == rtc_pkg::IDX_MASK);
  assign mapped   = hit_year || hit_alarm_second_field || hit_alarm_minute_field || hit_cfg || hit_stat || hit_mask;

  // Active-field masks by format
  always_comb begin
    year_mask = cfg.bcd_en ? rtc_pkg::MASK_FULL : rtc_pkg::MASK_YEAR_BIN; // see R2 see R4 see R5
    if (cfg.counter_mode) begin
      alm_mask = rtc_pkg::MASK_FULL; // see R8 see R11
    end else if (cfg.bcd_en) begin
      alm_mask = rtc_pkg::MASK_ALM_BCD; // see R6 see R9
    end else begin
      alm_mask = rtc_pkg::MASK_ALM_BIN; // see R7 see R10
    end
  end

  // Retained data bytes
  assign year_load    = wr && hit_year && !cfg.lock; // see R3
  assign year_dropped = wr && hit_year && cfg.lock; // see R3

  rtc_keep_byte #(
    .WIDTH (8)
  ) u_year (
    .pclk       (pclk),
    .load       (year_load),
    .load_value (wbyte),
    .value      (year_raw)
  );

  rtc_keep_byte #(
    .WIDTH (8)
  ) u_alarm_second_field (
    .pclk       (pclk),
    .load       (wr && hit_alarm_second_field), // see R14
    .load_value (wbyte),
    .value      (alarm_second_field_raw)
  );

  rtc_keep_byte #(
    .WIDTH (8)
  ) u_alarm_minute_field (
    .pclk       (pclk),
    .load       (wr && hit_alarm_minute_field), // see R14
    .load_value (wbyte),
    .value      (alarm_minute_field_raw)
  );

  // Reserved bits written nonzero
  always_comb begin
    rsvd_written = 1'b0;
    if (wr && hit_year && !cfg.lock) begin
      rsvd_written = (wbyte & ~year_mask) != 8'h00; // see R12
    end else if (wr && (hit_alarm_second_field || hit_alarm_minute_field)) begin
      rsvd_written = (wbyte & ~alm_mask) != 8'h00; // see R12
    end
  end

  // Alarm word and compare
  always_comb begin
    aw.b3 = alarm_second_field_raw; // see R8
    aw.b2 = alarm_minute_field_raw; // see R11
    aw.b1 = alarm_hours_byte; // see R13
    aw.b0 = alarm_dom_byte; // see R13
    alm_time.seconds = alarm_second_field_raw & alm_mask;
    alm_time.minutes = alarm_minute_field_raw & alm_mask;
    cnt_time.seconds = count_seconds & alm_mask;
    cnt_time.minutes = count_minutes & alm_mask;
    if (cfg.counter_mode) begin
      match_now = (count_word == aw); // see R14
    end else begin
      match_now = (cnt_time == alm_time); // see R14 see R2
    end
  end

  assign alarm_word = aw;
  assign year_value = year_raw & year_mask; // see R5

  // Events and interrupt state
  always_comb begin
    events                     = '0;
    events[rtc_pkg::EV_ALARM]  = match_now && !alarm_match;
    events[rtc_pkg::EV_LOCKED] = year_dropped;
    events[rtc_pkg::EV_RSVD]   = rsvd_written;
    next_status = status;
    if (stat_clear) begin
      next_status = '0;
    end
    next_status = next_status | events;
    next_int_mask = int_mask;
    if (wr && hit_mask) begin
      next_int_mask = pwdata[rtc_pkg::EV_W-1:0];
    end
    next_cfg = cfg;
    if (wr && hit_cfg) begin
      next_cfg.bcd_en       = pwdata[rtc_pkg::CFG_BCD_BIT];
      next_cfg.counter_mode = pwdata[rtc_pkg::CFG_MODE_BIT];
      next_cfg.lock         = pwdata[rtc_pkg::CFG_LOCK_BIT];
    end
    next_alarm_match = match_now;
    next_irq         = |(next_status & next_int_mask);
  end

  // Read data, latched in the setup cycle
  always_comb begin
    next_prdata  = prdata;
    next_pslverr = 1'b0;
    if (setup) begin
      next_prdata  = 32'h0000_0000;
      next_pslverr = !mapped;
      if (!pwrite) begin
        case (1'b1)
          hit_year: next_prdata[7:0] = year_raw & year_mask; // see R4 see R5
          hit_alarm_second_field: next_prdata[7:0] = alarm_second_field_raw & alm_mask; // see R6 see R7 see R8
          hit_alarm_minute_field: next_prdata[7:0] = alarm_minute_field_raw & alm_mask; // see R9 see R10 see R11
          hit_cfg:  next_prdata[rtc_pkg::CFG_W-1:0] = cfg;
          hit_stat: next_prdata[rtc_pkg::EV_W-1:0] = status;
          hit_mask: next_prdata[rtc_pkg::EV_W-1:0] = int_mask;
          default:  next_prdata = 32'h0000_0000;
        endcase
      end
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cfg         <= rtc_pkg::CFG_RST;
      status      <= rtc_pkg::STAT_RST;
      int_mask    <= rtc_pkg::MASK_RST;
      prdata      <= 32'h0000_0000;
      pslverr     <= 1'b0;
      irq         <= 1'b0;
      alarm_match <= 1'b0;
    end else begin
      cfg         <= next_cfg;
      status      <= next_status;
      int_mask    <= next_int_mask;
      prdata      <= next_prdata;
      pslverr     <= next_pslverr;
      irq         <= next_irq;
      alarm_match <= next_alarm_match;
    end
  end

  // Checks
  a_year_lock_hold: assert property (@(posedge pclk) disable iff (!presetn) // see R3
    (wr && hit_year && cfg.lock) |=> (year_raw == $past(year_raw)))
    else $error("year changed while locked");

  a_year_unlock_wr: assert property (@(posedge pclk) disable iff (!presetn) // see R3
    (wr && hit_year && !cfg.lock) |=> (year_raw == $past(wbyte)))
    else $error("year write lost while unlocked");

  a_alarm_second_field_locked_wr: assert property (@(posedge pclk) disable iff (!presetn) // see R14
    (wr && hit_alarm_second_field) |=> (alarm_second_field_raw == $past(wbyte)))
    else $error("alarm seconds write lost");

  a_alarm_minute_field_locked_wr: assert property (@(posedge pclk) disable iff (!presetn) // see R14
    (wr && hit_alarm_minute_field) |=> (alarm_minute_field_raw == $past(wbyte)))
    else $error("alarm minutes write lost");

  a_word_byte_order: assert property (@(posedge pclk) disable iff (!presetn) // see R13
    alarm_word[15:0] == {alarm_hours_byte, alarm_dom_byte})
    else $error("alarm word byte order wrong");

  a_word_sec_byte: assert property (@(posedge pclk) disable iff (!presetn) // see R8
    (wr && hit_alarm_second_field) |=> (alarm_word[31:24] == $past(wbyte)))
    else $error("alarm word byte 3 wrong");

  a_word_min_byte: assert property (@(posedge pclk) disable iff (!presetn) // see R11
    (wr && hit_alarm_minute_field) |=> (alarm_word[23:16] == $past(wbyte)))
    else $error("alarm word byte 2 wrong");

  a_year_bin_top: assert property (@(posedge pclk) disable iff (!presetn) // see R5
    !cfg.bcd_en |-> !year_value[7])
    else $error("binary year reserved bit visible");

  a_alarm_second_field_rd_bin: assert property (@(posedge pclk) disable iff (!presetn) // see R7
    (setup && !pwrite && hit_alarm_second_field && !cfg.bcd_en && !cfg.counter_mode)
      |=> (prdata[7:6] == 2'h0) && (prdata[5:0] == $past(alarm_second_field_raw[5:0])))
    else $error("binary alarm seconds read wrong");

  a_alarm_minute_field_rd_bcd: assert property (@(posedge pclk) disable iff (!presetn) // see R9
    (setup && !pwrite && hit_alarm_minute_field && cfg.bcd_en && !cfg.counter_mode)
      |=> (prdata[7:0] == {1'b0, $past(alarm_minute_field_raw[6:0])}))
    else $error("decimal alarm minutes read wrong");

  a_alarm_cnt_mode: assert property (@(posedge pclk) disable iff (!presetn) // see R11
    (cfg.counter_mode && count_word == alarm_word) |=> alarm_match)
    else $error("counter alarm not matched");

  a_rsvd_event: assert property (@(posedge pclk) disable iff (!presetn) // see R12
    (wr && hit_alarm_second_field && !cfg.counter_mode && wbyte[7]) |=> status[rtc_pkg::EV_RSVD])
    else $error("reserved write not flagged");

  a_stat_sticky: assert property (@(posedge pclk) disable iff (!presetn)
    (status[rtc_pkg::EV_ALARM] && !stat_clear) |=> status[rtc_pkg::EV_ALARM])
    else $error("status bit lost");

  a_irq_follows: assert property (@(posedge pclk) disable iff (!presetn)
    irq == |(status & int_mask))
    else $error("interrupt disagrees with status");

  a_year_rd_bcd: assert property (@(posedge pclk) disable iff (!presetn) // see R4
    (setup && !pwrite && hit_year && cfg.bcd_en) |=> (prdata[7:0] == $past(year_raw)))
    else $error("decimal year read wrong");

  a_alarm_minute_field_rd_bin: assert property (@(posedge pclk) disable iff (!presetn) // see R10
    (setup && !pwrite && hit_alarm_minute_field && !cfg.bcd_en && !cfg.counter_mode)
      |=> (prdata[7:0] == {2'h0, $past(alarm_minute_field_raw[5:0])}))
    else $error("binary alarm minutes read wrong");

  a_alarm_second_field_rd_cnt: assert property (@(posedge pclk) disable iff (!presetn) // see R8
    (setup && !pwrite && hit_alarm_second_field && cfg.counter_mode) |=> (prdata[7:0] == $past(alarm_second_field_raw)))
    else $error("counter alarm seconds read wrong");

  a_rsvd_year: assert property (@(posedge pclk) disable iff (!presetn) // see R12
    (wr && hit_year && !cfg.lock && !cfg.bcd_en && wbyte[7]) |=> status[rtc_pkg::EV_RSVD])
    else $error("reserved year write not flagged");

  a_unmapped_err: assert property (@(posedge pclk) disable iff (!presetn)
    (setup && !mapped) |=> pslverr)
    else $error("unmapped access without error");

  a_stat_read_clear: assert property (@(posedge pclk) disable iff (!presetn)
    stat_clear |=> (status == $past(events)))
    else $error("status not cleared by read");

  a_time_match: assert property (@(posedge pclk) disable iff (!presetn) // see R2
    (!cfg.counter_mode && cnt_time == alm_time) |=> alarm_match)
    else $error("time alarm not matched");

  a_lock_event: assert property (@(posedge pclk) disable iff (!presetn) // see R3
    (wr && hit_year && cfg.lock) |=> status[rtc_pkg::EV_LOCKED])
    else $error("dropped year write not flagged");

  c_locked_drop: cover property (@(posedge pclk) disable iff (!presetn)
    wr && hit_year && cfg.lock);

  c_counter_match: cover property (@(posedge pclk) disable iff (!presetn)
    cfg.counter_mode && match_now && !alarm_match);

  c_time_match_irq: cover property (@(posedge pclk) disable iff (!presetn)
    !cfg.counter_mode && events[rtc_pkg::EV_ALARM] ##1 irq);

  c_unmapped: cover property (@(posedge pclk) disable iff (!presetn)
    access && pslverr);

endmodule

`default_nettype wire

// ==== bench/rtc_year_alarm_regs_bench.sv ====
`timescale 1ns/100ps
`default_nettype none

module rtc_year_alarm_regs_bench;
  logic        pclk       = 1'b0;
  logic        presetn    = 1'b0;
  logic        psel       = 1'b0;
  logic        penable    = 1'b0;
  logic        pwrite     = 1'b0;
  logic [15:0] paddr      = 16'h0000;
  logic [31:0] pwdata     = 32'h0000_0000;
  logic [7:0]  hrs        = 8'h00;
  logic [7:0]  dom        = 8'h00;
  logic [7:0]  cnt_sec    = 8'hFF;
  logic [7:0]  cnt_min    = 8'hFF;
  logic [31:0] cnt_word   = 32'hFFFF_FFFF;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic [31:0] alarm_word;
  logic [7:0]  year_value;
  logic        alarm_match;
  logic        irq;
  logic [33:0] notes[$];
  logic [33:0] note;
  logic [7:0]  year_exp;
  int          mismatches = 0;
  int          tests_run  = 0;
  int          seed       = 32'h100A40C1;

  rtc_year_alarm_regs dut_u (
    .pclk             (pclk),
    .presetn          (presetn),
    .psel             (psel),
    .penable          (penable),
    .pwrite           (pwrite),
    .paddr            (paddr),
    .pwdata           (pwdata),
    .prdata           (prdata),
    .pready           (pready),
    .pslverr          (pslverr),
    .alarm_hours_byte (hrs),
    .alarm_dom_byte   (dom),
    .count_seconds    (cnt_sec),
    .count_minutes    (cnt_min),
    .count_word       (cnt_word),
    .alarm_word       (alarm_word),
    .year_value       (year_value),
    .alarm_match      (alarm_match),
    .irq              (irq)
  );

  initial begin
    forever #20 pclk = ~pclk;
  end

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      mismatches++;
      $display("ERROR %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic complete_run();
    $display("Checks %0d, mismatches %0d", tests_run, mismatches);
    if (mismatches == 0 && tests_run > 0) begin
      $display("Simulation passed");
    end else begin
      $display("Simulation failed");
    end
    $finish;
  endtask

  // One APB transfer, setup then access until pready
  task automatic xfer(input logic wr, input logic [11:0] idx, input logic [31:0] d);
    @(posedge pclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= wr;
    paddr   <= {2'b00, idx, 2'b00};
    pwdata  <= d;
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready !== 1'b1) @(posedge pclk);
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic wr(input logic [11:0] idx, input logic [31:0] d);
    xfer(1'b1, idx, d);
  endtask

  task automatic rd(input logic [11:0] idx, input logic [31:0] exp, input logic err,
                    input logic chk);
    notes.push_back({chk, err, exp});
    xfer(1'b0, idx, 32'h0000_0000);
  endtask

  task automatic settle(input int n);
    repeat (n) @(posedge pclk);
    @(negedge pclk);
  endtask

  // Read results checked where they appear
  always @(posedge pclk) begin
    if (psel && penable && pready && !pwrite && notes.size() > 0) begin
      note = notes.pop_front();
      if (note[33]) begin
        check(prdata, note[31:0]);
        check({31'h0, pslverr}, {31'h0, note[32]});
      end
    end
  end

  initial begin
    repeat (20000) @(posedge pclk);
    mismatches++;
    complete_run();
  end

  initial begin
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    wr(rtc_pkg::IDX_YEAR, 32'h0000_0063);
    wr(rtc_pkg::IDX_ALARM_SECOND_FIELD, 32'h0000_003B);
    wr(rtc_pkg::IDX_ALARM_MINUTE_FIELD, 32'h0000_0017);
    rd(rtc_pkg::IDX_STAT, 32'h0, 1'b0, 1'b0);
    wr(rtc_pkg::IDX_YEAR, 32'h0000_00E3);
    wr(rtc_pkg::IDX_ALARM_MINUTE_FIELD, 32'h0000_00D7);
    rd(rtc_pkg::IDX_YEAR, 32'h0000_0063, 1'b0, 1'b1);
    rd(rtc_pkg::IDX_ALARM_MINUTE_FIELD, 32'h0000_0017, 1'b0, 1'b1);
    rd(rtc_pkg::IDX_ALARM_SECOND_FIELD, 32'h0000_003B, 1'b0, 1'b1);
    rd(rtc_pkg::IDX_STAT, 32'h0000_0004, 1'b0, 1'b1);
    rd(12'hF39, 32'h0, 1'b1, 1'b1);
    settle(0);
    check({24'h0, year_value}, 32'h0000_0063);
    // Decimal format
    wr(rtc_pkg::IDX_CFG, 32'h0000_0001);
    rd(rtc_pkg::IDX_YEAR, 32'h0000_00E3, 1'b0, 1'b1);
    rd(rtc_pkg::IDX_ALARM_MINUTE_FIELD, 32'h0000_0057, 1'b0, 1'b1);
    wr(rtc_pkg::IDX_ALARM_SECOND_FIELD, 32'h0000_0059);
    rd(rtc_pkg::IDX_ALARM_SECOND_FIELD, 32'h0000_0059, 1'b0, 1'b1);
    for (int i = 0; i < 8; i++) begin
      year_exp = {4'($unsigned($random(seed)) % 10), 4'($unsigned($random(seed)) % 10)};
      wr(rtc_pkg::IDX_YEAR, {24'h0, year_exp});
      rd(rtc_pkg::IDX_YEAR, {24'h0, year_exp}, 1'b0, 1'b1);
      settle(0);
      check({24'h0, year_value}, {24'h0, year_exp});
    end
    // Counter mode alarm word
    @(posedge pclk);
    hrs <= 8'($random(seed));
    dom <= 8'($random(seed));
    wr(rtc_pkg::IDX_CFG, 32'h0000_0002);
    wr(rtc_pkg::IDX_ALARM_SECOND_FIELD, 32'h0000_00A5);
    wr(rtc_pkg::IDX_ALARM_MINUTE_FIELD, 32'h0000_005A);
    rd(rtc_pkg::IDX_ALARM_SECOND_FIELD, 32'h0000_00A5, 1'b0, 1'b1);
    rd(rtc_pkg::IDX_ALARM_MINUTE_FIELD, 32'h0000_005A, 1'b0, 1'b1);
    settle(0);
    check(alarm_word, {8'hA5, 8'h5A, hrs, dom});
    @(posedge pclk);
    cnt_word <= {8'hA5, 8'h5A, hrs, dom};
    settle(1);
    check({31'h0, alarm_match}, 32'h1);
    @(posedge pclk);
    cnt_word <= 32'hFFFF_FFFF;
    // Binary alarm compare with interrupt
    wr(rtc_pkg::IDX_CFG, 32'h0000_0000);
    wr(rtc_pkg::IDX_MASK, 32'h0000_0001);
    rd(rtc_pkg::IDX_STAT, 32'h0, 1'b0, 1'b0);
    @(posedge pclk);
    cnt_sec <= 8'hE5;
    cnt_min <= 8'hDA;
    settle(1);
    check({31'h0, alarm_match}, 32'h1);
    settle(1);
    check({31'h0, irq}, 32'h1);
    rd(rtc_pkg::IDX_STAT, 32'h0000_0001, 1'b0, 1'b1);
    settle(1);
    check({31'h0, irq}, 32'h0);
    @(posedge pclk);
    cnt_sec <= 8'hFF;
    cnt_min <= 8'hFF;
    // Locked year
    wr(rtc_pkg::IDX_CFG, 32'h0000_0004);
    wr(rtc_pkg::IDX_MASK, 32'h0000_0002);
    rd(rtc_pkg::IDX_STAT, 32'h0, 1'b0, 1'b0);
    wr(rtc_pkg::IDX_YEAR, 32'h0000_0012);
    settle(1);
    check({31'h0, irq}, 32'h1);
    wr(rtc_pkg::IDX_ALARM_SECOND_FIELD, 32'h0000_0030);
    rd(rtc_pkg::IDX_YEAR, {24'h0, year_exp & 8'h7F}, 1'b0, 1'b1);
    rd(rtc_pkg::IDX_ALARM_SECOND_FIELD, 32'h0000_0030, 1'b0, 1'b1);
    rd(rtc_pkg::IDX_STAT, 32'h0000_0002, 1'b0, 1'b1);
    wr(rtc_pkg::IDX_CFG, 32'h0000_0000);
    wr(rtc_pkg::IDX_YEAR, 32'h0000_0012);
    rd(rtc_pkg::IDX_YEAR, 32'h0000_0012, 1'b0, 1'b1);
    // Contents survive a reset
    @(posedge pclk);
    presetn <= 1'b0;
    repeat (2) @(posedge pclk);
    presetn <= 1'b1;
    rd(rtc_pkg::IDX_YEAR, 32'h0000_0012, 1'b0, 1'b1);
    rd(rtc_pkg::IDX_ALARM_SECOND_FIELD, 32'h0000_0030, 1'b0, 1'b1);
    rd(rtc_pkg::IDX_ALARM_MINUTE_FIELD, 32'h0000_001A, 1'b0, 1'b1);
    settle(1);
    complete_run();
  end
endmodule

`default_nettype wire
